// ==== tb/waveform_output_timing_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module waveform_output_timing_test;
  logic mclk = 0, rst = 1, arm = 0, stop = 0, go = 0, fall = 0, plow = 0, inv = 0;
  logic [1:0] sel = 2'h0;
  logic [2:0] ssrc = 3'h0, psrc = 3'h7;
  waveform_output_timing_pkg::trig_in_t pins = '0;
  logic t10, t12, t13, stb, stbt, strt, psd, run;
  logic xpin, ext = 0;
  logic [23:0] dly = 24'h00_0000;
  int miscompares = 0, n_tests = 0;
  always #2 mclk = ~mclk;
  wot_far_side far (.mclk(mclk), .rst(rst), .tick_10m(t10), .tick_12m8(t12), .tick_13m1(t13),
    .ext_pin(xpin));
  waveform_output_timing uut (.mclk(mclk), .rst(rst), .tb_int_10m(t10), .tb_int_12m8(t12),
    .tb_int_13m1(t13), .tb_external(xpin), .tb_use_external(ext), .tb_select(sel),
    .update_divisor(24'h00_0002), .start_delay(dly), .task_arm(arm),
    .task_stop(stop), .sw_start_cmd(go), .start_source(ssrc), .start_falling(fall),
    .pause_source(psrc), .pause_active_low(plow), .trig_pins(pins), .strobe_invert(inv),
    .output_update_strobe(stb), .output_update_strobe_terminal(stbt),
    .generation_start_trigger(strt), .generation_paused(psd), .generation_running(run));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles from one strobe to the next, bounded
  task automatic gap(output int n);
    n = 0;
    @(posedge mclk iff stb);
    do begin
      @(posedge mclk);
      n++;
    end while (!stb && n < 999);
  endtask
  task automatic start_sw();
    @(posedge mclk);
    ssrc <= 3'h0;
    arm <= 1;
    @(posedge mclk);
    arm <= 0;
    go <= 1;
    @(posedge mclk);
    go <= 0;
    @(posedge mclk);
    chk(strt, 1);
  endtask
  task automatic halt();
    stop <= 1;
    @(posedge mclk);
    stop <= 0;
  endtask
  task automatic t_run(input logic [1:0] s, input int per);
    int n;
    sel <= s;
    inv <= s[0];
    start_sw();
    gap(n);
    chk(n, per * 2);
    chk({stb, stbt, run}, {1'b1, ~inv, 1'b1});
    halt();
    $display("done run %0d", s);
  endtask
  // Three ticks of delay plus two of divider before the first strobe
  task automatic t_delay();
    int n;
    sel <= 2'h2;
    dly <= 24'h00_0003;
    start_sw();
    n = 0;
    while (!stb && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk(n > 70 && n < 100, 1);
    halt();
    dly <= 24'h00_0000;
    $display("done delay");
  endtask
  task automatic t_ext();
    int n;
    ext <= 1;
    start_sw();
    gap(n);
    chk(n, 32);
    halt();
    $display("done ext");
  endtask
  task automatic t_edge(input int k);
    int n;
    @(posedge mclk);
    ssrc <= 3'(k);
    fall <= k[0];
    pins <= k[0] ? 5'h1f : 5'h00;
    arm <= 1;
    @(posedge mclk);
    arm <= 0;
    repeat (6) @(posedge mclk);
    chk(strt, 0);
    pins[5 - k] <= ~k[0];
    n = 0;
    while (!strt && n < 12) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 12, 1);
    halt();
    $display("done edge %0d", k);
  endtask
  task automatic t_pause(input logic lo, input logic x);
    int n;
    int c;
    @(posedge mclk);
    ext <= x;
    psrc <= 3'h4;
    plow <= lo;
    pins <= lo ? 5'h02 : 5'h00;
    start_sw();
    gap(n);
    pins <= lo ? 5'h00 : 5'h02;
    repeat (60) @(posedge mclk);
    chk(psd, 1);
    c = 0;
    repeat (150) @(posedge mclk) c += stb;
    chk(c, 0);
    pins <= lo ? 5'h02 : 5'h00;
    n = 0;
    while (!stb && n < 99) begin
      @(posedge mclk);
      n++;
    end
    chk(x ? (n > 30 && n < 75) : (n < 60), 1);
    halt();
    psrc <= 3'h7;
    $display("done pause %0d", lo);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
  // Analog threshold pin is driven only as a running input task would
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    for (int s = 0; s < 4; s++) t_run(2'(s), s == 0 ? 25 : (s == 1 ? 20 : 19));
    t_delay();
    t_ext();
    for (int k = 1; k < 6; k++) t_edge(k);
    t_pause(1'b0, 1'b0);
    t_pause(1'b1, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/wot_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module wot_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic task_arm,
  input wire logic task_stop,
  input wire logic sw_start_cmd,
  input wire logic [2:0] start_source,
  input wire logic [23:0] start_delay,
  input wire logic strobe_invert,
  input wire logic output_update_strobe,
  input wire logic output_update_strobe_terminal,
  input wire logic generation_start_trigger,
  input wire logic generation_paused,
  input wire logic generation_running
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Arm, then a software start while armed
  sequence s_arm_go;
    task_arm && !generation_running && !task_stop ##1 sw_start_cmd && !task_stop
      && start_source == 3'h0;
  endsequence
  a_sw_start_taken: assert property (s_arm_go |=> generation_start_trigger)
    else $error("software start not answered");
  a_strobe_pin_polarity: assert property (!$past(rst) |-> output_update_strobe_terminal ==
    (output_update_strobe ^ $past(strobe_invert))) else $error("terminal polarity wrong");
  a_start_one_pulse: assert property (generation_start_trigger |=> !generation_start_trigger)
    else $error("start pulse too long");
  a_start_sets_run: assert property (generation_start_trigger && start_delay == 24'h00_0000
    |-> ##[0:1] generation_running)
    else $error("start without running");
  a_stop_ends_run: assert property (task_stop |-> ##2 !generation_running)
    else $error("stop ignored");
  a_start_needs_cmd: assert property (generation_start_trigger && start_source == 3'h0
    |-> $past(sw_start_cmd)) else $error("start without command");
  a_strobe_only_run: assert property (output_update_strobe |-> generation_running ||
    $past(generation_running)) else $error("strobe while idle");
  a_pause_mutes: assert property (generation_paused [*3] |-> !output_update_strobe)
    else $error("strobe while paused");
endmodule
bind waveform_output_timing wot_checker chk (.mclk, .rst, .task_arm, .task_stop, .sw_start_cmd,
  .start_source, .start_delay, .strobe_invert, .output_update_strobe, .output_update_strobe_terminal,
  .generation_start_trigger, .generation_paused, .generation_running);
`default_nettype wire

// ==== tb/wot_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
module wot_far_side (
  input wire logic mclk,
  input wire logic rst,
  output logic tick_10m,
  output logic tick_12m8,
  output logic tick_13m1,
  output logic ext_pin
);
  int n16;
  int n10;
  int n12;
  int n13;
  // Free-running timebases; periods rounded to whole 4 ns cycles
  always_ff @(posedge mclk) begin
    n10 <= (rst || n10 == 24) ? 0 : n10 + 1;
    n12 <= (rst || n12 == 19) ? 0 : n12 + 1;
    n13 <= (rst || n13 == 18) ? 0 : n13 + 1;
    n16 <= (rst || n16 == 15) ? 0 : n16 + 1;
  end
  // External timebase pin, square wave of 16 cycles
  assign ext_pin = n16 < 8;
  assign tick_10m = n10 == 24;
  assign tick_12m8 = n12 == 19;
  assign tick_13m1 = n13 == 18;
endmodule
`default_nettype wire

// ==== verilog/waveform_output_timing.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "waveform_output_timing_map.svh"
module waveform_output_timing #(
  parameter int DIV_W = 24,
  parameter int DLY_W = 24
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tb_int_10m, // Internal timebase ticks, mclk domain pulses
  input wire logic tb_int_12m8,
  input wire logic tb_int_13m1,
  input wire logic tb_external, // From a pin, asynchronous
  input wire logic tb_use_external,
  input wire logic [1:0] tb_select,
  input wire logic [DIV_W-1:0] update_divisor,
  input wire logic [DLY_W-1:0] start_delay,
  input wire logic task_arm,
  input wire logic task_stop,
  input wire logic sw_start_cmd,
  input wire logic [2:0] start_source,
  input wire logic start_falling,
  input wire logic [2:0] pause_source,
  input wire logic pause_active_low,
  input wire waveform_output_timing_pkg::trig_in_t trig_pins,
  input wire logic strobe_invert,
  output logic output_update_strobe,
  output logic output_update_strobe_terminal,
  output logic generation_start_trigger,
  output logic generation_paused,
  output logic generation_running
);
  // Two-stage synchronisers for asynchronous trigger and timebase pins [R20]
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] async_in;
  assign async_in = {tb_external, trig_pins};
  // One synchroniser per pin bit; only the second stage is read downstream
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (rst) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= async_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic ext_tb_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_tb_q <= 1'b0;
    end else begin
      ext_tb_q <= sync2_q[5];
    end
  end
  // Rising edge of the synchronised pin is one external tick
  // Pin rate must stay below mclk/2 or ticks are lost
  logic ext_tb_tick;
  assign ext_tb_tick = sync2_q[5] & ~ext_tb_q;

  // Timebase select; auto picks the fastest internal one [R4] [R5]
  logic tb_tick;
  always_comb begin
    if (tb_use_external) begin
      tb_tick = ext_tb_tick;
    end else begin
      case (tb_select)
        `TB_SEL_10M: tb_tick = tb_int_10m;
        `TB_SEL_12M8: tb_tick = tb_int_12m8;
        `TB_SEL_13M1: tb_tick = tb_int_13m1;
        default: tb_tick = tb_int_13m1; // [R5]
      endcase
    end
  end

  // Start source mux [R10] [R12]
  // Unused source codes read low, so they can never start a task
  logic start_level;
  always_comb begin
    case (start_source)
      `SRC_TERMINAL: start_level = sync2_q[4];
      `SRC_IN_REF: start_level = sync2_q[3];
      `SRC_IN_START: start_level = sync2_q[2];
      `SRC_ANALOG: start_level = sync2_q[1];
      `SRC_INTERNAL: start_level = sync2_q[0];
      default: start_level = 1'b0;
    endcase
  end
  logic start_level_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_level_q <= 1'b0;
    end else begin
      start_level_q <= start_level;
    end
  end
  logic start_edge;
  logic hw_start;
  // Edge polarity chosen by configuration [R9] [R12]
  assign start_edge = start_falling ? (start_level_q & ~start_level)
                                    : (~start_level_q & start_level);
  // No trigger configured or host pulse: software command starts [R7] [R10]
  assign hw_start = (start_source == `SRC_SOFTWARE || start_source == `SRC_NONE) ?
                    sw_start_cmd : start_edge;

  // Pause source mux, level sensitive [R18] [R19]
  // Unused codes read high: with active-high pause a bad setting holds output still
  logic pause_raw;
  always_comb begin
    case (pause_source)
      `SRC_TERMINAL: pause_raw = sync2_q[4];
      `SRC_IN_REF: pause_raw = sync2_q[3];
      `SRC_IN_START: pause_raw = sync2_q[2];
      `SRC_ANALOG: pause_raw = sync2_q[1];
      `SRC_INTERNAL: pause_raw = sync2_q[0];
      default: pause_raw = 1'b1;
    endcase
  end
  logic pause_now;
  assign pause_now = (pause_source == `SRC_NONE) ? 1'b0 : (pause_raw ^ pause_active_low);

  // Generation state machine; a stop in the same cycle as a start sends it to idle, but generation_start_trigger still pulses
  waveform_output_timing_pkg::gen_state_t state_q;
  waveform_output_timing_pkg::gen_state_t state_d;
  logic [DLY_W-1:0] delay_cnt_q;
  logic [DLY_W-1:0] delay_cnt_d;
  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_cnt_d;
  logic period_end;
  logic delay_done;
  logic run_start;
  assign period_end = tb_tick && (div_cnt_q <= `DIV_RESET);
  assign delay_done = (delay_cnt_q == '0);
  assign run_start = (state_q == waveform_output_timing_pkg::ST_ARMED) && hw_start;

  // Next state: arm from idle, start only while armed [R7]
  always_comb begin
    state_d = state_q;
    case (state_q)
      waveform_output_timing_pkg::ST_IDLE: begin
        if (task_arm) begin
          state_d = waveform_output_timing_pkg::ST_ARMED;
        end
      end
      waveform_output_timing_pkg::ST_ARMED: begin
        if (hw_start) begin
          state_d = waveform_output_timing_pkg::ST_RUN; // [R7]
        end
      end
      waveform_output_timing_pkg::ST_RUN: begin
        state_d = waveform_output_timing_pkg::ST_RUN;
      end
      default: begin
        state_d = waveform_output_timing_pkg::ST_IDLE;
      end
    endcase
  end

  // Rearming needs a stop first, so a stray arm cannot restart a task
  always_ff @(posedge mclk) begin
    if (rst || task_stop) begin
      state_q <= waveform_output_timing_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Start delay in timebase ticks, honoured only with an internal timebase [R8]
  always_comb begin
    delay_cnt_d = delay_cnt_q;
    if (run_start) begin
      delay_cnt_d = tb_use_external ? '0 : start_delay; // [R8]
    end else if (!delay_done && tb_tick) begin
      delay_cnt_d = delay_cnt_q - 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      delay_cnt_q <= '0;
    end else begin
      delay_cnt_q <= delay_cnt_d;
    end
  end

  // Pause entered only at period boundaries, released in any cycle, so no period is cut short [R14] [R15]
  logic pause_q;
  logic pause_d;
  logic resume_wait_q;
  logic resume_wait_d;
  logic running;
  logic pause_release;
  assign running = (state_q == waveform_output_timing_pkg::ST_RUN) && delay_done;
  assign pause_release = pause_q && !pause_now;
  always_comb begin
    pause_d = pause_q;
    if (running && period_end && pause_now) begin
      pause_d = 1'b1; // [R15]
    end else if (pause_release) begin
      pause_d = 1'b0; // [R16] [R17]
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || run_start) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= pause_d;
    end
  end

  // External timebase: after release wait one more strobe edge [R17]
  always_comb begin
    resume_wait_d = resume_wait_q;
    if (pause_release && tb_use_external) begin
      resume_wait_d = 1'b1; // [R17]
    end else if (resume_wait_q && period_end) begin
      resume_wait_d = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || run_start) begin
      resume_wait_q <= 1'b0;
    end else begin
      resume_wait_q <= resume_wait_d;
    end
  end

  // Divider reload on task start and on internal resume [R3] [R6] [R20]
  // Internal resume gives a full period: even spacing traded for latency
  logic strobe_fire;
  assign strobe_fire = running && period_end && !pause_now && !pause_q && !resume_wait_q;
  always_comb begin
    div_cnt_d = div_cnt_q;
    if (pause_release && !tb_use_external) begin
      div_cnt_d = update_divisor; // [R16]
    end else if (running && tb_tick) begin
      div_cnt_d = period_end ? update_divisor : div_cnt_q - 1'b1; // [R6]
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || run_start) begin
      div_cnt_q <= update_divisor; // [R20]
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // Registered outputs; the timebase itself never leaves the block [R3]
  // Update strobe to the output modules, one mclk wide [R1]
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_update_strobe <= 1'b0;
    end else begin
      output_update_strobe <= strobe_fire; // [R1]
    end
  end

  // Terminal copy, active high unless inverted [R2]
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_update_strobe_terminal <= 1'b0;
    end else begin
      output_update_strobe_terminal <= strobe_fire ^ strobe_invert; // [R2]
    end
  end

  // Start pulse for terminal routing, one cycle high [R11]
  always_ff @(posedge mclk) begin
    if (rst) begin
      generation_start_trigger <= 1'b0;
    end else begin
      generation_start_trigger <= run_start; // [R11]
    end
  end

  // Paused also covers the wait for a strobe edge after release [R14]
  always_ff @(posedge mclk) begin
    if (rst) begin
      generation_paused <= 1'b0;
    end else begin
      generation_paused <= pause_q | resume_wait_q; // [R14]
    end
  end

  // Running only once the start delay has expired
  always_ff @(posedge mclk) begin
    if (rst) begin
      generation_running <= 1'b0;
    end else begin
      generation_running <= running;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/waveform_output_timing_map.svh ====
// Operation
// R1 - One strobe per period updates all channels
// R2 - Routed update strobe active high by default
// R3 - Strobe divided from timebase; timebase never output
// R4 - Three internal timebases for oversampling modules
// R5 - No choice: fastest internal timebase selected
// R6 - Update rate is timebase over integer
// R7 - Start on trigger, else software command
// R8 - Programmable start delay with internal timebase
// R9 - Rising or falling start edge selectable
// R10 - Start sources: host, terminals, input triggers
// R11 - Routed start trigger is active-high pulse
// R12 - Analog event start on first configured edge
// R13 - Host runs analog input task for threshold
// R14 - Pause suppresses updates, lets current finish
// R15 - New pause applies from next period
// R16 - Internal timebase: resume at pause release
// R17 - Other source: resume on next strobe edge
// R18 - Pause level high or low selectable
// R19 - Analog event pause at configured level
// R20 - Sync triggers; reload divider on task start
`ifndef WAVEFORM_OUTPUT_TIMING_MAP_SVH
`define WAVEFORM_OUTPUT_TIMING_MAP_SVH
`define TB_SEL_10M 2'h0
`define TB_SEL_12M8 2'h1
`define TB_SEL_13M1 2'h2
`define TB_SEL_AUTO 2'h3
`define SRC_SOFTWARE 3'h0
`define SRC_TERMINAL 3'h1
`define SRC_IN_REF 3'h2
`define SRC_IN_START 3'h3
`define SRC_ANALOG 3'h4
`define SRC_INTERNAL 3'h5
`define SRC_NONE 3'h7
`define DIV_RESET 24'h00_0001
`endif

// ==== verilog/waveform_output_timing_pkg.sv ====
package waveform_output_timing_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN = 3'b100
  } gen_state_t;
  typedef struct packed {
    logic terminal;
    logic in_ref;
    logic in_start;
    logic analog;
    logic internal_sig;
  } trig_in_t;
endpackage
